/* rtl/sao_params.svh */
/*
  Constants of the stream attribute override block: register offsets,
  field positions of the stream entry attribute slice, reset values.
  Assumes it is included by bare name by the top module.
*/
`ifndef SAO_PARAMS_SVH
`define SAO_PARAMS_SVH

// ==========================================================================
// register map (byte addresses)
`define SAO_REG_CTRL        12'h000
`define SAO_REG_CAP         12'h004
`define SAO_REG_COUNT       12'h008
`define SAO_REG_LAST        12'h00c
`define SAO_CTRL_PCIE_BIT   0
`define SAO_CTRL_CLR_BIT    1
`define SAO_CAP_TYPE_BIT    0
`define SAO_CAP_PERM_BIT    1
`define SAO_CTRL_RESET      1'b0

// ==========================================================================
// stream entry slice: bits [111:96] of the entry
`define SAO_STE_BASE        96
`define SAO_STE_ATTR_LO     96
`define SAO_STE_ATTR_HI     99
`define SAO_STE_MT_BIT      100
`define SAO_STE_ALLOC_LO    101
`define SAO_STE_ALLOC_HI    104
`define SAO_STE_SH_LO       108
`define SAO_STE_SH_HI       109
`define SAO_STE_NS_LO       110
`define SAO_STE_NS_HI       111

// ==========================================================================
// encodings
`define SAO_MT_DEV_NGNRNE   4'h0
`define SAO_SH_NSH          2'h0
`define SAO_SH_OSH          2'h2
`define SAO_SH_ISH          2'h3
`define SAO_SHOVR_INCOMING  2'h1
`define SAO_NSOVR_SECURE    2'h2
`define SAO_NSOVR_NONSEC    2'h3

`endif

/* rtl/sao_pkg.sv */
/*
  Types of the stream attribute override block.
  Assumes sao_params.svh sits on the include path.
*/
package sao_pkg;

  // ========================================================================
  // transaction attributes
  typedef struct packed {
    logic [3:0] mem_type;
    logic       inner_ra;
    logic       inner_wa;
    logic       inner_tr;
    logic       outer_ra;
    logic       outer_wa;
    logic       outer_tr;
    logic [1:0] share;
    logic       ns;
  } sao_attr_t;

  typedef struct packed {
    sao_attr_t attr;
    logic      is_pcie;
    logic      s1_ns;
  } sao_txn_t;

  typedef struct packed {
    logic [15:0] word;
    logic        secure_table;
    logic        s1_enable;
    logic        s2_enable;
  } sao_ste_t;

  typedef struct packed {
    sao_attr_t attr;
    logic      s1_ns_out;
    logic      s2_ipa_ns;
    logic      s2_used;
  } sao_out_t;

  // ========================================================================
  // apb carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sao_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sao_apb_rsp_t;

endpackage

/* rtl/sao_top.sv */
/*
  Stream attribute override: takes a client transaction with the
  attribute slice of its stream entry and produces the overridden
  memory type, hints, shareability and security attribute one cycle
  later. Registers on APB. Assumes the stream table lookup has already
  supplied the entry slice and stage enables alongside the transaction.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sao_params.svh"

module sao_top
  import sao_pkg::*;
#(
  parameter bit TYPE_OVR_CAP = 1'b1,
  parameter bit PERM_OVR_CAP = 1'b1,
  parameter int COUNT_W      = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire sao_apb_req_t apb_req,
  output var  sao_apb_rsp_t apb_rsp_q,
  input  wire logic         in_valid,
  input  wire sao_txn_t     in_txn,
  input  wire sao_ste_t     in_ste,
  output logic              out_valid_q,
  output var  sao_out_t     out_q
);

  initial begin
    if (COUNT_W < 1 || COUNT_W > 32) begin
      $error("COUNT_W must lie between 1 and 32");
    end
  end

  // ========================================================================
  // attribute helpers
  localparam int B = `SAO_STE_BASE;

  // reserved normal codes with no inner type fall to the strictest device
  function automatic logic [3:0] norm_type(input logic [3:0] t);
    if (t[3:2] != 2'h0 && t[1:0] == 2'h0) begin
      norm_type = `SAO_MT_DEV_NGNRNE;
    end else begin
      norm_type = t;
    end
  endfunction

  // one half of a normal type is write-back or write-through
  function automatic logic half_cacheable(input logic [3:0] t,
                                          input logic       outer);
    logic [1:0] h;
    h = outer ? t[3:2] : t[1:0];
    half_cacheable = (t[3:2] != 2'h0) && h[1];
  endfunction

  // ========================================================================
  // control register
  logic               pcie_apply_q;
  logic [COUNT_W-1:0] count_q;
  logic [12:0]        last_attr_q;
  logic               apb_wr;
  logic               apb_setup;

  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr    = apb_req.psel & apb_req.penable & apb_rsp_q.pready
                   & apb_req.pwrite;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pcie_apply_q <= `SAO_CTRL_RESET;
    end else if (apb_wr && apb_req.paddr == `SAO_REG_CTRL) begin
      pcie_apply_q <= apb_req.pwdata[`SAO_CTRL_PCIE_BIT];
    end
  end

  // ========================================================================
  // apb answer: ready in the first access cycle
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `SAO_REG_CTRL) || (a == `SAO_REG_CAP) ||
             (a == `SAO_REG_COUNT) || (a == `SAO_REG_LAST);
  endfunction

  logic [31:0] rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (apb_req.paddr)
      `SAO_REG_CTRL: begin
        rd_data[`SAO_CTRL_PCIE_BIT] = pcie_apply_q;
      end
      `SAO_REG_CAP: begin
        rd_data[`SAO_CAP_TYPE_BIT] = TYPE_OVR_CAP;
        rd_data[`SAO_CAP_PERM_BIT] = PERM_OVR_CAP;
      end
      `SAO_REG_COUNT: begin
        rd_data[COUNT_W-1:0] = count_q;
      end
      `SAO_REG_LAST: begin
        rd_data[12:0] = last_attr_q;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      apb_rsp_q <= '0;
    end else if (apb_setup && !apb_rsp_q.pready) begin
      apb_rsp_q.pready  <= 1'b1;
      apb_rsp_q.pslverr <= ~mapped(apb_req.paddr);
      apb_rsp_q.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      apb_rsp_q <= '0;
    end
  end

  // ========================================================================
  // override datapath
  sao_attr_t  inc;
  sao_attr_t  res;
  logic [3:0] mt_value;
  logic       mt_enable;
  logic [3:0] alloc;
  logic [1:0] sh_ovr;
  logic [1:0] ns_ovr;
  logic       ovr_ok;
  logic       t_eff;
  logic       any_cache;
  logic       s1_ns;

  always_comb begin
    inc       = in_txn.attr;
    mt_value  = in_ste.word[`SAO_STE_ATTR_HI-B:`SAO_STE_ATTR_LO-B];
    mt_enable = in_ste.word[`SAO_STE_MT_BIT-B];
    alloc     = in_ste.word[`SAO_STE_ALLOC_HI-B:`SAO_STE_ALLOC_LO-B];
    sh_ovr    = in_ste.word[`SAO_STE_SH_HI-B:`SAO_STE_SH_LO-B];
    ns_ovr    = in_ste.word[`SAO_STE_NS_HI-B:`SAO_STE_NS_LO-B];
    // capability off or pcie stream not covered: type, hint and shareability fields are ignored
    ovr_ok    = TYPE_OVR_CAP && (!in_txn.is_pcie || pcie_apply_q);
    res       = inc;
    res.mem_type = norm_type(inc.mem_type);
    if (ovr_ok && mt_enable) begin
      res.mem_type = norm_type(mt_value);
    end
    // hints
    t_eff = alloc[0] & (alloc[2] | alloc[1]);
    if (ovr_ok && alloc[3]) begin
      if (half_cacheable(res.mem_type, 1'b0)) begin
        res.inner_ra = alloc[2];
        res.inner_wa = alloc[1];
        res.inner_tr = t_eff;
      end
      if (half_cacheable(res.mem_type, 1'b1)) begin
        res.outer_ra = alloc[2];
        res.outer_wa = alloc[1];
        res.outer_tr = t_eff;
      end
    end
    // shareability
    any_cache = half_cacheable(res.mem_type, 1'b0) |
                half_cacheable(res.mem_type, 1'b1);
    if (!any_cache) begin
      res.share = `SAO_SH_OSH;
    end else if (ovr_ok && sh_ovr != `SAO_SHOVR_INCOMING) begin
      unique case (sh_ovr)
        2'h0:    res.share = `SAO_SH_NSH;
        2'h2:    res.share = `SAO_SH_OSH;
        default: res.share = `SAO_SH_ISH;
      endcase
    end
    // security attribute leaving stage 1
    s1_ns = inc.ns;
    if (in_ste.secure_table) begin
      if (in_ste.s1_enable) begin
        s1_ns = in_txn.s1_ns;
      end else if (PERM_OVR_CAP) begin
        unique case (ns_ovr)
          `SAO_NSOVR_SECURE: s1_ns = 1'b0;
          `SAO_NSOVR_NONSEC: s1_ns = 1'b1;
          default:           s1_ns = inc.ns;
        endcase
      end
    end
    res.ns = s1_ns;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= in_valid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      out_q <= '0;
    end else if (in_valid) begin
      out_q.attr      <= res;
      out_q.s1_ns_out <= s1_ns;
      out_q.s2_used   <= in_ste.secure_table & in_ste.s2_enable;
      // stage 2 address space picked by the stage 1 result
      out_q.s2_ipa_ns <= in_ste.secure_table & in_ste.s2_enable
                         ? s1_ns : 1'b0;
    end
  end

  // ========================================================================
  // status: transaction count and last result
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (in_valid) begin
      count_q <= count_q + {{(COUNT_W-1){1'b0}}, 1'b1};
    end else if (apb_wr && apb_req.paddr == `SAO_REG_CTRL &&
                 apb_req.pwdata[`SAO_CTRL_CLR_BIT]) begin
      count_q <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      last_attr_q <= '0;
    end else if (in_valid) begin
      last_attr_q <= res;
    end
  end

endmodule
`default_nettype wire

/* tb/sao_chk.sv */
/*
  Checker of the attribute override block, bound to sao_top.
  Assumes only the top module's ports and its two capability flags.
*/
`timescale 1ns/1ps
`default_nettype none
module sao_chk
  import sao_pkg::*;
#(
  parameter bit TYPE_OVR_CAP = 1'b1,
  parameter bit PERM_OVR_CAP = 1'b1
) (
  input wire logic         ref_clk,
  input wire logic         reset_n,
  input wire sao_apb_req_t apb_req,
  input wire sao_apb_rsp_t apb_rsp_q,
  input wire logic         in_valid,
  input wire sao_txn_t     in_txn,
  input wire sao_ste_t     in_ste,
  input wire logic         out_valid_q,
  input wire sao_out_t     out_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic [15:0] w   = in_ste.word;
  wire logic        ovr = TYPE_OVR_CAP && !in_txn.is_pcie;
  wire sao_attr_t   oa  = out_q.attr;
  // ======================================================================
  // transaction path and apb ready
  sequence s_mt;
    in_valid && ovr && w[4];
  endsequence
  sequence s_hint;
    in_valid && ovr && w[8] && !w[4] && in_txn.attr.mem_type == 4'hf;
  endsequence
  AST_LAT: assert property (in_valid |=> out_valid_q)
    else $error("no result one cycle after a transaction");
  AST_IDLE: assert property (!in_valid |=> !out_valid_q)
    else $error("result without a transaction");
  AST_MT_PASS: assert property (
    in_valid && !w[4] && in_txn.attr.mem_type[1:0] != 2'h0
    |=> oa.mem_type == $past(in_txn.attr.mem_type))
    else $error("incoming memory type not kept");
  AST_MT_VAL: assert property (s_mt ##0 (w[1:0] != 2'h0)
    |=> oa.mem_type == $past(w[3:0]))
    else $error("memory type not replaced");
  AST_MT_RSV: assert property (s_mt ##0 (w[1:0] == 2'h0)
    |=> oa.mem_type == 4'h0)
    else $error("reserved type not strictest device");
  AST_HINT: assert property (s_hint |=> oa.inner_ra == $past(w[7])
    && oa.outer_ra == $past(w[7]) && oa.inner_wa == $past(w[6])
    && oa.outer_wa == $past(w[6]))
    else $error("hint override wrong");
  AST_OSH: assert property (out_valid_q &&
    (oa.mem_type[3:2] == 2'h0 || oa.mem_type == 4'h5) |-> oa.share == 2'h2)
    else $error("device or uncached not outer shareable");
  AST_NS_NSTAB: assert property (
    in_valid && !in_ste.secure_table |=> oa.ns == $past(in_txn.attr.ns))
    else $error("security changed for non-secure table");
  AST_NS_S1: assert property (
    in_valid && in_ste.secure_table && in_ste.s1_enable
    |=> oa.ns == $past(in_txn.s1_ns))
    else $error("security not from translation");
  AST_NS_BYP: assert property (in_valid && PERM_OVR_CAP &&
    in_ste.secure_table && !in_ste.s1_enable && w[15]
    |=> oa.ns == $past(w[14]))
    else $error("security override not applied");
  AST_APB: assert property (apb_req.psel && !apb_req.penable
    |=> apb_rsp_q.pready)
    else $error("no ready in access cycle");
endmodule
bind sao_top sao_chk #(.TYPE_OVR_CAP(TYPE_OVR_CAP),
  .PERM_OVR_CAP(PERM_OVR_CAP)) sao_chk_inst (.ref_clk(ref_clk),
  .reset_n(reset_n), .apb_req(apb_req), .apb_rsp_q(apb_rsp_q),
  .in_valid(in_valid), .in_txn(in_txn), .in_ste(in_ste),
  .out_valid_q(out_valid_q), .out_q(out_q));
`default_nettype wire

/* tb/sao_client.sv */
/*
  Client device model: presents transactions with their entry slice.
  Assumes the caller idles it before any pause in traffic.
*/
`timescale 1ns/1ps
`default_nettype none
module sao_client
  import sao_pkg::*;
(
  input  wire logic     ref_clk,
  output var  logic     in_valid,
  output var  sao_txn_t in_txn,
  output var  sao_ste_t in_ste
);
  initial begin
    in_valid = 1'b0;
    in_txn   = '0;
    in_ste   = '0;
  end
  task automatic send(input sao_txn_t t, input sao_ste_t s);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_txn   <= t;
    in_ste   <= s;
  endtask
  // idle lines carry the last transaction inverted, and unchanged again on every second idle cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      in_valid <= 1'b0;
      in_txn   <= ~in_txn;
      in_ste   <= ~in_ste;
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Testbench of the attribute override block.
  Assumes the default capability flags of sao_top.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sao_pkg::*;
;
  logic         ref_clk;
  logic         reset_n;
  logic         in_valid;
  logic         out_valid;
  logic         pa;
  logic [12:0]  last_a;
  sao_apb_req_t apb_req;
  sao_apb_rsp_t apb_rsp;
  sao_txn_t     in_txn;
  sao_ste_t     in_ste;
  sao_out_t     out_r;
  int           miscompares;
  int           samples_checked;
  logic [15:0]  exp_q[$];

  sao_top sao_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .apb_req(apb_req), .apb_rsp_q(apb_rsp), .in_valid(in_valid),
    .in_txn(in_txn), .in_ste(in_ste), .out_valid_q(out_valid),
    .out_q(out_r));
  sao_client sao_client_inst (.ref_clk(ref_clk), .in_valid(in_valid),
    .in_txn(in_txn), .in_ste(in_ste));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    // a result still owed at the end is a lost transaction
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  // whole result word: attributes, stage 1 security, stage 2 fields
  task automatic cmp_out(input sao_out_t got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  // ======================================================================
  // expected result
  function automatic logic [15:0] expect_f(sao_txn_t t, sao_ste_t s);
    sao_attr_t  a;
    logic       o;
    logic       u;
    logic [3:0] m;
    logic [2:0] h;
    a = t.attr;
    o = !t.is_pcie || pa;
    m = (o && s.word[4]) ? s.word[3:0] : a.mem_type;
    if (m[1:0] == 2'h0) m = 4'h0;
    a.mem_type = m;
    h = {s.word[7:6], s.word[5] & |s.word[7:6]};
    if (o && s.word[8] && m[3:2] != 2'h0 && m[1])
      {a.inner_ra, a.inner_wa, a.inner_tr} = h;
    if (o && s.word[8] && m[3])
      {a.outer_ra, a.outer_wa, a.outer_tr} = h;
    if (!(m[3] || (m[3:2] != 2'h0 && m[1]))) a.share = 2'h2;
    else if (o && s.word[13:12] != 2'h1) a.share = s.word[13:12];
    if (s.secure_table && s.s1_enable) a.ns = t.s1_ns;
    else if (s.secure_table && s.word[15]) a.ns = s.word[14];
    u = s.secure_table & s.s2_enable;
    return {a, a.ns, u & a.ns, u};
  endfunction

  task automatic txn(input sao_txn_t t, input sao_ste_t s);
    logic [15:0] e;
    if (t.attr.share == 2'h1) t.attr.share = 2'h0;
    e = expect_f(t, s);
    exp_q.push_back(e);
    last_a = e[15:3];
    sao_client_inst.send(t, s);
  endtask

  task automatic rnd(input int n);
    repeat (n) begin
      txn(15'($urandom), 19'($urandom));
      if ($urandom_range(3) == 0) sao_client_inst.idle(1);
    end
    sao_client_inst.idle(2);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    r = {apb_rsp.pslverr, apb_rsp.prdata};
    apb_req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(r, x);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask

  // ======================================================================
  // result monitor
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) miscompares++;
      else cmp_out(out_r, exp_q.pop_front());
    end
  end

  initial begin
    #50000;
    miscompares++;
    conclude();
  end

  initial begin
    sao_txn_t t;
    sao_ste_t s;
    apb_req = '0;
    reset_n = 1'b0;
    pa = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'h0f98));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(12'h004, 33'h3);
    rd(12'h000, 33'h0);
    rd(12'h010, 33'h100000000);
    for (int i = 0; i < 20; i++) begin
      t = 15'($urandom);
      s = 19'($urandom);
      t.is_pcie = 1'b0;
      if (i < 16) begin
        s.word[4] = 1'b1;
        s.word[3:0] = i[3:0];
      end else begin
        s.secure_table = 1'b1;
        s.s1_enable = 1'b0;
        s.word[15:14] = i[1:0];
      end
      txn(t, s);
    end
    sao_client_inst.idle(2);
    rnd(150);
    wr(12'h000, 32'h1);
    pa = 1'b1;
    rnd(150);
    rd(12'h008, 33'd320);
    rd(12'h00c, {20'h0, last_a});
    wr(12'h000, 32'h2);
    pa = 1'b0;
    rd(12'h008, 33'h0);
    rd(12'h000, 33'h0);
    conclude();
  end
endmodule
`default_nettype wire
